// >>> hdl/bcl_pkg.sv
// Constants for the bridge capability list register bank
package bcl_pkg;

  localparam int ADDR_W = 8;
  localparam int DATA_W = 32;
  localparam int NUM_CAP_WORDS = 4;

  // Byte addresses of the capability dwords
  localparam logic [7:0] OFF_SUBSYS_CAP  = 8'hA8;
  localparam logic [7:0] OFF_CARD_CODES  = 8'hAC;
  localparam logic [7:0] OFF_EXPRESS_CAP = 8'hB0;
  localparam logic [7:0] OFF_DEV_CAP     = 8'hB4;
  localparam logic [NUM_CAP_WORDS-1:0][7:0] CAP_OFFS =
    {OFF_DEV_CAP, OFF_EXPRESS_CAP, OFF_CARD_CODES, OFF_SUBSYS_CAP};

  // Block control and status words
  localparam logic [7:0] OFF_CTRL   = 8'hE0;
  localparam logic [7:0] OFF_STATUS = 8'hE4;
  localparam int CTRL_SLOT_ID_EN_BIT = 0;
  localparam int STATUS_REVERSE_BIT  = 0;
  localparam int STATUS_STRAP_BIT    = 1;
  localparam logic CTRL_SLOT_ID_EN_RESET = 1'b0;

  // Field positions
  localparam int ID_LSB       = 0;
  localparam int NEXT_LSB     = 8;
  localparam int VENDOR_LSB   = 0;
  localparam int MODEL_LSB    = 16;
  localparam int VERSION_LSB  = 16;
  localparam int PORT_LSB     = 20;
  localparam int SLOT_IMP_BIT = 24;
  localparam int MSG_NUM_LSB  = 25;
  localparam int PAYLOAD_LSB  = 0;

  // Fixed field values
  localparam logic [7:0] SUBSYS_CAP_ID    = 8'h0D;
  localparam logic [7:0] NEXT_TO_EXPRESS  = 8'hB0;
  localparam logic [7:0] NEXT_TO_SLOT_ID  = 8'hA0;
  localparam logic [7:0] EXPRESS_CAP_ID   = 8'h10;
  localparam logic [7:0] EXPRESS_NEXT     = 8'hF0;
  localparam logic [3:0] CAP_VERSION      = 4'h1;
  localparam logic [3:0] PORT_FWD_BRIDGE  = 4'h7;
  localparam logic [3:0] PORT_REV_BRIDGE  = 4'h8;
  localparam logic [4:0] IRQ_MSG_NUM      = 5'h00;
  localparam logic [2:0] PAYLOAD_RESET    = 3'h2;
  localparam logic [2:0] PAYLOAD_MAX_CODE = 3'h3;

endpackage

// >>> hdl/bcl_rom_if.sv
// Link between the register bank and its capability word table
`timescale 1ns/1ps
interface bcl_rom_if;
  logic [7:0]  addr;
  logic        rev_mode;
  logic        slot_id_en;
  logic [31:0] rdata;
  logic        hit;

  modport requester (output addr, rev_mode, slot_id_en, input rdata, hit);
  modport table_side (input addr, rev_mode, slot_id_en, output rdata, hit);
endinterface

// >>> hdl/bcl_cap_rom.sv
// Capability word table: builds and selects the read-only dwords
`timescale 1ns/1ps
module bcl_cap_rom #(
  parameter logic [15:0] CARD_VENDOR = 16'hA5C3,
  parameter logic [15:0] CARD_MODEL  = 16'h5A3C,
  parameter logic [2:0]  MAX_PAYLOAD = 3'h2
) (
  bcl_rom_if.table_side rif
);

  localparam int N = bcl_pkg::NUM_CAP_WORDS;

  logic [31:0] words [N];
  logic [31:0] masked [N];
  logic [N-1:0] sel;

  always_comb begin
    for (int k = 0; k < N; k++) begin
      words[k] = 32'h0000_0000;
    end
    // Subsystem capability, upper half reserved
    words[0][bcl_pkg::ID_LSB +: 8] = bcl_pkg::SUBSYS_CAP_ID;
    words[0][bcl_pkg::NEXT_LSB +: 8] = rif.slot_id_en ?
      bcl_pkg::NEXT_TO_SLOT_ID : bcl_pkg::NEXT_TO_EXPRESS;
    words[1][bcl_pkg::VENDOR_LSB +: 16] = CARD_VENDOR;
    words[1][bcl_pkg::MODEL_LSB +: 16] = CARD_MODEL;
    words[2][bcl_pkg::ID_LSB +: 8] = bcl_pkg::EXPRESS_CAP_ID;
    words[2][bcl_pkg::NEXT_LSB +: 8] = bcl_pkg::EXPRESS_NEXT;
    words[2][bcl_pkg::VERSION_LSB +: 4] = bcl_pkg::CAP_VERSION;
    words[2][bcl_pkg::PORT_LSB +: 4] = rif.rev_mode ?
      bcl_pkg::PORT_REV_BRIDGE : bcl_pkg::PORT_FWD_BRIDGE;
    words[2][bcl_pkg::SLOT_IMP_BIT] = rif.rev_mode;
    words[2][bcl_pkg::MSG_NUM_LSB +: 5] = bcl_pkg::IRQ_MSG_NUM;
    words[3][bcl_pkg::PAYLOAD_LSB +: 3] = MAX_PAYLOAD;
  end

  genvar i;
  for (i = 0; i < N; i++) begin : g_word
    assign sel[i] = (rif.addr == bcl_pkg::CAP_OFFS[i]);
    assign masked[i] = sel[i] ? words[i] : 32'h0000_0000;
  end

  always_comb begin
    rif.rdata = 32'h0000_0000;
    for (int k = 0; k < N; k++) begin
      rif.rdata = rif.rdata | masked[k];
    end
    rif.hit = |sel;
  end

endmodule

// >>> hdl/bcl_regs.sv
// APB register bank for the bridge capability list dwords
//
// Contract
// - Dword A8h bits 7:0 read 0Dh, subsystem capability; writes ignored.
// - A8h bits 15:8 read B0h, or A0h with slot identification enabled.
// - ACh bits 15:0 read the card vendor code, read-only.
// - ACh bits 31:16 read the card model code, read-only.
// - B0h bits 7:0 read 10h, the express capability identifier.
// - B0h bits 15:8 read F0h, read-only link to the next capability.
// - B0h bits 23:20 read 0111 forward, 1000 reverse bridge.
// - B0h bit 24 reads 0 forward, 1 reverse.
//
// Decided for this implementation: the APB interface to the registers.
`timescale 1ns/1ps
module bcl_regs #(
  parameter logic [15:0] CARD_VENDOR = 16'hA5C3, // Arbitrary value
  parameter logic [15:0] CARD_MODEL  = 16'h5A3C, // Arbitrary value
  parameter logic [2:0]  MAX_PAYLOAD = bcl_pkg::PAYLOAD_RESET
) (
  // Clock and reset
  input  wire logic        pclk,
  input  wire logic        presetn,
  // APB slave
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [7:0]  paddr,
  input  wire logic [31:0] pwdata,
  input  wire logic [3:0]  pstrb,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  // Bridge mode strap and state
  input  wire logic        rev_mode_strap,
  output logic             rev_mode,
  output logic             slot_id_en
);

  if (MAX_PAYLOAD > bcl_pkg::PAYLOAD_MAX_CODE) begin : g_bad_payload
    $error("Payload code above the supported range");
  end

  bcl_rom_if rif ();

  logic        ctrl_slot_reg;
  logic        ctrl_slot_next;
  logic        rev_reg;
  logic        rev_next;
  logic        strap_done_reg;
  logic        strap_done_next;
  logic [31:0] rdata_reg;
  logic [31:0] rdata_next;
  logic        err_reg;
  logic        err_next;

  logic setup_phase;
  logic access_phase;
  logic own_hit;
  logic [31:0] own_rdata;

  assign setup_phase  = psel && !penable;
  assign access_phase = psel && penable;

  // Capability table lookup
  assign rif.addr       = paddr;
  assign rif.rev_mode   = rev_reg;
  assign rif.slot_id_en = ctrl_slot_reg;

  bcl_cap_rom #(
    .CARD_VENDOR (CARD_VENDOR),
    .CARD_MODEL  (CARD_MODEL),
    .MAX_PAYLOAD (MAX_PAYLOAD)
  ) u_rom (
    .rif (rif)
  );

  // Control and status words of the block itself
  always_comb begin
    own_rdata = 32'h0000_0000;
    own_hit   = 1'b0;
    if (paddr == bcl_pkg::OFF_CTRL) begin
      own_hit = 1'b1;
      own_rdata[bcl_pkg::CTRL_SLOT_ID_EN_BIT] = ctrl_slot_reg;
    end else if (paddr == bcl_pkg::OFF_STATUS) begin
      own_hit = 1'b1;
      own_rdata[bcl_pkg::STATUS_REVERSE_BIT] = rev_reg;
      own_rdata[bcl_pkg::STATUS_STRAP_BIT]   = strap_done_reg;
    end
  end

  // Next state of strap, control and bus answer
  always_comb begin
    ctrl_slot_next  = ctrl_slot_reg;
    rev_next        = rev_reg;
    strap_done_next = strap_done_reg;
    rdata_next      = rdata_reg;
    err_next        = err_reg;
    // Strap caught once at the first edge after reset release
    if (!strap_done_reg) begin
      rev_next        = rev_mode_strap;
      strap_done_next = 1'b1;
    end
    // Answer prepared in the setup cycle, held through access
    if (setup_phase) begin
      err_next   = !(rif.hit || own_hit);
      rdata_next = 32'h0000_0000;
      if (!pwrite) begin
        rdata_next = rif.hit ? rif.rdata : own_rdata;
      end
    end
    // Only the control word takes writes; table words stay fixed
    if (access_phase && pwrite && paddr == bcl_pkg::OFF_CTRL &&
        pstrb[0]) begin
      ctrl_slot_next = pwdata[bcl_pkg::CTRL_SLOT_ID_EN_BIT];
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctrl_slot_reg  <= bcl_pkg::CTRL_SLOT_ID_EN_RESET;
      rev_reg        <= 1'b0;
      strap_done_reg <= 1'b0;
      rdata_reg      <= 32'h0000_0000;
      err_reg        <= 1'b0;
    end else begin
      ctrl_slot_reg  <= ctrl_slot_next;
      rev_reg        <= rev_next;
      strap_done_reg <= strap_done_next;
      rdata_reg      <= rdata_next;
      err_reg        <= err_next;
    end
  end

  // Zero wait states: every access phase completes at once
  assign pready     = access_phase;
  assign prdata     = rdata_reg;
  assign pslverr    = access_phase && err_reg;
  assign rev_mode   = rev_reg;
  assign slot_id_en = ctrl_slot_reg;

  default clocking cb @(posedge pclk);
  endclocking
  default disable iff (!presetn);

  sequence rd_at(logic [7:0] a);
    psel && penable && !pwrite && paddr == a;
  endsequence

  sequence rd_setup(logic [7:0] a);
    psel && !penable && !pwrite && paddr == a;
  endsequence

  // Read values of the table words, then write, strap and unmapped-address checks
  a_subsys_id_val: assert property (
    rd_at(bcl_pkg::OFF_SUBSYS_CAP)
    |-> prdata[7:0] == 8'h0D)
    else $error("Subsystem capability identifier wrong");

  a_subsys_next_link: assert property (
    rd_setup(bcl_pkg::OFF_SUBSYS_CAP) ##1 penable
    |-> prdata[15:8] == ($past(ctrl_slot_reg) ? 8'hA0 : 8'hB0))
    else $error("Subsystem next link wrong");

  a_vendor_code_val: assert property (
    rd_at(bcl_pkg::OFF_CARD_CODES)
    |-> prdata[15:0] == CARD_VENDOR)
    else $error("Card vendor code wrong");

  a_model_code_val: assert property (
    rd_at(bcl_pkg::OFF_CARD_CODES)
    |-> prdata[31:16] == CARD_MODEL)
    else $error("Card model code wrong");

  a_express_id_val: assert property (
    rd_at(bcl_pkg::OFF_EXPRESS_CAP)
    |-> prdata[7:0] == 8'h10 && !pslverr)
    else $error("Express capability identifier wrong");

  a_express_next_val: assert property (
    rd_at(bcl_pkg::OFF_EXPRESS_CAP)
    |-> prdata[15:8] == 8'hF0 && prdata[19:16] == 4'h1)
    else $error("Express next link wrong");

  a_port_type_mode: assert property (
    rd_at(bcl_pkg::OFF_EXPRESS_CAP)
    |-> prdata[23:20] == (rev_mode ? 4'h8 : 4'h7))
    else $error("Port type does not follow bridge mode");

  a_slot_impl_mode: assert property (
    rd_at(bcl_pkg::OFF_EXPRESS_CAP)
    |-> prdata[24] == rev_mode)
    else $error("Slot implemented bit does not follow mode");

  a_reserved_zero: assert property (
    (rd_at(bcl_pkg::OFF_SUBSYS_CAP) |-> prdata[31:16] == 16'h0000) and
    (rd_at(bcl_pkg::OFF_EXPRESS_CAP) |-> prdata[31:25] == 7'h00))
    else $error("Reserved bits not zero");

  a_payload_code: assert property (
    rd_at(bcl_pkg::OFF_DEV_CAP)
    |-> prdata[2:0] == MAX_PAYLOAD && prdata[31:3] == 29'h0)
    else $error("Payload code wrong");

  a_ro_write_kept: assert property (
    psel && penable && pwrite && paddr != bcl_pkg::OFF_CTRL
    |=> $stable(ctrl_slot_reg))
    else $error("Write to a fixed word changed state");

  a_ctrl_write_take: assert property (
    psel && penable && pwrite && paddr == bcl_pkg::OFF_CTRL && pstrb[0]
    |=> slot_id_en == $past(pwdata[0]))
    else $error("Control write not taken");

  a_strap_once: assert property (
    strap_done_reg |=> strap_done_reg && $stable(rev_reg))
    else $error("Bridge mode changed after capture");

  a_unmapped_err: assert property (
    psel && !penable && paddr != bcl_pkg::OFF_SUBSYS_CAP &&
    paddr != bcl_pkg::OFF_CARD_CODES && paddr != bcl_pkg::OFF_EXPRESS_CAP &&
    paddr != bcl_pkg::OFF_DEV_CAP && paddr != bcl_pkg::OFF_CTRL &&
    paddr != bcl_pkg::OFF_STATUS ##1 psel && penable
    |-> pslverr && pready)
    else $error("Unmapped access not flagged");

  // Bus protocol and own-word checks
  a_ready_access: assert property (
    psel && penable |-> pready)
    else $error("Access cycle without ready");

  a_idle_quiet: assert property (
    !(psel && penable) |-> !pready && !pslverr)
    else $error("Ready or error outside an access cycle");

  a_mapped_no_err: assert property (
    psel && !penable && (paddr == bcl_pkg::OFF_SUBSYS_CAP ||
    paddr == bcl_pkg::OFF_CARD_CODES || paddr == bcl_pkg::OFF_EXPRESS_CAP ||
    paddr == bcl_pkg::OFF_DEV_CAP || paddr == bcl_pkg::OFF_CTRL ||
    paddr == bcl_pkg::OFF_STATUS) ##1 psel && penable
    |-> !pslverr)
    else $error("Mapped access flagged as error");

  a_unmapped_zero: assert property (
    psel && penable && !pwrite && pslverr |-> prdata == 32'h0000_0000)
    else $error("Unmapped read returned data");

  a_write_no_rdata: assert property (
    psel && !penable && pwrite ##1 psel && penable
    |-> prdata == 32'h0000_0000)
    else $error("Write answered with read data");

  a_nostrb_ignored: assert property (
    psel && penable && pwrite && paddr == bcl_pkg::OFF_CTRL && !pstrb[0]
    |=> $stable(ctrl_slot_reg))
    else $error("Control write without strobe taken");

  a_read_keeps_ctrl: assert property (
    psel && penable && !pwrite |=> $stable(ctrl_slot_reg))
    else $error("Read changed the control word");

  a_ctrl_readback: assert property (
    rd_setup(bcl_pkg::OFF_CTRL) ##1 penable
    |-> prdata == {31'h0, $past(ctrl_slot_reg)})
    else $error("Control word read back wrong");

  a_status_read: assert property (
    rd_setup(bcl_pkg::OFF_STATUS) ##1 penable
    |-> prdata[1] == $past(strap_done_reg) &&
        prdata[0] == $past(rev_reg) && prdata[31:2] == 30'h0)
    else $error("Status word read back wrong");

  a_strap_capture: assert property (
    $rose(strap_done_reg) |-> rev_reg == $past(rev_mode_strap))
    else $error("Bridge mode not taken from the strap");

  a_slot_reset_off: assert property (
    $rose(strap_done_reg) |-> !slot_id_en)
    else $error("Slot identification enabled out of reset");

  a_rdata_setup_only: assert property (
    !(psel && !penable) |=> $stable(prdata))
    else $error("Read data changed outside a setup cycle");

  // Main scenarios
  c_slot_link_read: cover property (
    slot_id_en and rd_at(bcl_pkg::OFF_SUBSYS_CAP));

  c_reverse_read: cover property (
    rev_mode and rd_at(bcl_pkg::OFF_EXPRESS_CAP));

  c_ctrl_write: cover property (
    psel && penable && pwrite && paddr == bcl_pkg::OFF_CTRL && pstrb[0]);

  c_error_answer: cover property (pslverr);

  c_back_to_back: cover property (
    rd_at(bcl_pkg::OFF_CARD_CODES) ##1 rd_setup(bcl_pkg::OFF_DEV_CAP));

endmodule

// >>> test/test_bridge_capability_list_regs.sv
// Self-checking bench for the capability list register bank
`timescale 1ns/1ps
module test_bridge_capability_list_regs;
  localparam logic [15:0] VENDOR = 16'h1E2D; // Arbitrary value
  localparam logic [15:0] MODEL  = 16'h3C4B; // Arbitrary value
  localparam logic [2:0]  PAYLD  = 3'h3;

  typedef struct packed {
    logic [31:0] data;
    logic        err;
    logic        rd;
  } bcl_note_t;

  logic        pclk;
  logic        presetn;
  logic        psel;
  logic        penable;
  logic        pwrite;
  logic [7:0]  paddr;
  logic [31:0] pwdata;
  logic [3:0]  pstrb;
  logic [31:0] prdata;
  logic        pready;
  logic        pslverr;
  logic        rev_mode_strap;
  logic        rev_mode;
  logic        slot_id_en;
  int          err_total;
  int          checks;
  bit          held;
  logic [31:0] seed;
  bcl_note_t   notes[$];
  bcl_note_t   cur;

  bcl_regs #(
    .CARD_VENDOR (VENDOR),
    .CARD_MODEL  (MODEL),
    .MAX_PAYLOAD (PAYLD)
  ) u_dut (
    .pclk           (pclk),
    .presetn        (presetn),
    .psel           (psel),
    .penable        (penable),
    .pwrite         (pwrite),
    .paddr          (paddr),
    .pwdata         (pwdata),
    .pstrb          (pstrb),
    .prdata         (prdata),
    .pready         (pready),
    .pslverr        (pslverr),
    .rev_mode_strap (rev_mode_strap),
    .rev_mode       (rev_mode),
    .slot_id_en     (slot_id_en)
  );

  always #10 pclk = ~pclk;

  function automatic logic [31:0] xs();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed;
  endfunction

  function automatic logic [31:0] e_a8(input logic slot);
    return {16'h0000, slot ? 8'hA0 : 8'hB0, 8'h0D};
  endfunction

  function automatic logic [31:0] e_b0(input logic rev);
    return {2'h0, 5'h00, rev, rev ? 4'h8 : 4'h7, 4'h1, 8'hF0, 8'h10};
  endfunction

  task automatic chk_word(input logic [31:0] got, input logic [31:0] exp);
    checks++;
    if (got !== exp) begin
      err_total++;
      $display("[ERR] %0t read data %h expected %h", $time, got, exp);
    end
  endtask

  task automatic chk_bit(input logic got, input logic exp);
    checks++;
    if (got !== exp) begin
      err_total++;
      $display("[ERR] %0t flag %b expected %b", $time, got, exp);
    end
  endtask

  // One APB transfer; keep leaves psel up for a back-to-back setup
  task automatic apb(input logic w, input logic [7:0] a,
                     input logic [31:0] d, input logic [3:0] s,
                     input logic [31:0] e, input logic er, input bit keep);
    if (!held) @(posedge pclk);
    notes.push_back('{data: e, err: er, rd: !w});
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= w;
    paddr   <= a;
    pwdata  <= d;
    pstrb   <= s;
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    while (pready !== 1'b1) begin
      @(posedge pclk);
    end
    held = keep;
    if (!keep) begin
      psel    <= 1'b0;
      penable <= 1'b0;
    end
  endtask

  task automatic rd(input logic [7:0] a, input logic [31:0] e,
                    input logic er, input bit keep);
    apb(1'b0, a, xs(), 4'hF, e, er, keep);
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d,
                    input logic [3:0] s, input logic er);
    apb(1'b1, a, d, s, 32'h0000_0000, er, 1'b0);
  endtask

  // Result watcher: oldest note against each completed transfer
  always @(posedge pclk) begin
    if (psel && penable && pready === 1'b1) begin
      if (notes.size() == 0) begin
        err_total++;
        $display("[ERR] %0t transfer with no expectation", $time);
      end else begin
        cur = notes.pop_front();
        if (cur.rd) chk_word(prdata, cur.data);
        chk_bit(pslverr, cur.err);
      end
    end
  end

  task automatic do_reset(input logic strap);
    @(posedge pclk);
    presetn        <= 1'b0;
    rev_mode_strap <= strap;
    psel           <= 1'b0;
    penable        <= 1'b0;
    held = 0;
    repeat (16) @(posedge pclk);
    presetn <= 1'b1;
    repeat (2) @(posedge pclk);
  endtask

  task automatic run_mode(input logic rev);
    int          i;
    logic [7:0]  offs [4];
    logic [31:0] ex [4];
    do_reset(rev);
    offs = '{8'hA8, 8'hAC, 8'hB0, 8'hB4};
    ex = '{e_a8(1'b0), {MODEL, VENDOR}, e_b0(rev), {29'h0, PAYLD}};
    chk_bit(rev_mode, rev);
    chk_bit(slot_id_en, 1'b0);
    rd(8'hA8, ex[0], 1'b0, 1'b1);
    rd(8'hAC, ex[1], 1'b0, 1'b1);
    rd(8'hB0, ex[2], 1'b0, 1'b1);
    rd(8'hB4, ex[3], 1'b0, 1'b0);
    rd(8'hE4, {30'h0, 1'b1, rev}, 1'b0, 1'b0);
    for (i = 0; i < 4; i++) begin
      wr(offs[i], xs(), 4'hF, 1'b0);
      rd(offs[i], ex[i], 1'b0, 1'b0);
    end
    wr(8'hE0, 32'h0000_0001, 4'h0, 1'b0);
    rd(8'hA8, e_a8(1'b0), 1'b0, 1'b0);
    wr(8'hE0, 32'h0000_0001, 4'hF, 1'b0);
    @(negedge pclk);
    chk_bit(slot_id_en, 1'b1);
    rd(8'hA8, e_a8(1'b1), 1'b0, 1'b1);
    rd(8'hE0, 32'h0000_0001, 1'b0, 1'b0);
    rd(8'h40, 32'h0000_0000, 1'b1, 1'b0);
    wr(8'hB8, xs(), 4'hF, 1'b1);
    rd(8'hB0, e_b0(rev), 1'b0, 1'b0);
  endtask

  task automatic print_verdict();
    $display("Checks %0d, errors %0d", checks, err_total);
    if (err_total == 0 && checks > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask

  initial begin
    pclk           = 1'b0;
    presetn        = 1'b0;
    psel           = 1'b0;
    penable        = 1'b0;
    pwrite         = 1'b0;
    paddr          = 8'h00;
    pwdata         = 32'h0000_0000;
    pstrb          = 4'h0;
    rev_mode_strap = 1'b0;
    err_total      = 0;
    checks         = 0;
    held           = 0;
    seed           = 32'h0000_005F;
    run_mode(1'b0);
    run_mode(1'b1);
    repeat (3) @(posedge pclk);
    print_verdict();
  end

  // Watchdog well beyond the fewer than two hundred cycles the run needs
  initial begin
    #100000;
    err_total++;
    $display("[ERR] %0t watchdog expired", $time);
    print_verdict();
  end
endmodule
